// ==== shared/dpm_regs.vh ====
// dpm_regs.vh: register offsets, field positions and reset values
// assumes inclusion by the power-mode / dual-port input block files
`ifndef DPM_REGS_VH
`define DPM_REGS_VH

// control register indices (printed offsets); byte address = 4 * index
`define DPM_IDX_CTRL0      4'h0
`define DPM_IDX_CTRL1      4'h1
`define DPM_IDX_CTRL2      4'h2
`define DPM_IDX_CTRL3      4'h3
`define DPM_IDX_CTRL4      4'h4
`define DPM_IDX_STATUS     4'h5
`define DPM_IDX_MASK       4'h6
`define DPM_IDX_SAMPLE     4'h7

// field positions
`define DPM_BIT_SLEEP      3
`define DPM_BIT_PWRDN      4
`define DPM_BIT_ONEPORT    6
`define DPM_BIT_LOCK_CLK   0
`define DPM_BIT_CLKINV     4
`define DPM_BIT_CLK_SDO    7
`define DPM_BIT_PLL_ON     7
`define DPM_BIT_CLK_EN     0

// status / mask bits
`define DPM_ST_LOCK_RISE   0
`define DPM_ST_LOCK_FALL   1
`define DPM_ST_PD_EXIT     2
`define DPM_ST_FLUSHED     3

// reset values
`define DPM_RST_CTRL       8'h00
`define DPM_RST_CTRL3      8'h01

// flush after power-down, in cycles of the data-rate clock
`define DPM_FLUSH_WORDS    5'd16

`endif

// ==== hw/dpm_rate_div.v ====
// dpm_rate_div.v: divider making a one-cycle data-rate enable pulse
// assumes a single clock; divisor is sampled when the count wraps
`timescale 1ns/1ps

module dpm_rate_div #(
  parameter WIDTH = 8
) (
  input  wire             aclk,
  input  wire             aresetn,
  input  wire             run,
  input  wire [WIDTH-1:0] divisor,
  output reg              tick,
  output reg              phase
);

  reg [WIDTH-1:0] count;

  // count down; tick on wrap, phase is a clock image set on wrap and cleared once count <= divisor >> 1
  always @(posedge aclk) begin
    if (!aresetn || !run) begin
      count <= {WIDTH{1'b0}};
      tick  <= 1'b0;
      phase <= 1'b0;
    end else if (count == {WIDTH{1'b0}}) begin
      count <= divisor;
      tick  <= 1'b1;
      phase <= 1'b1;
    end else begin
      count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
      tick  <= 1'b0;
      if (count <= (divisor >> 1))
        phase <= 1'b0;
    end
  end

endmodule // dpm_rate_div

// ==== hw/dpm_core.v ====
// dpm_core.v: power modes, two-port sample capture, clock/lock pin routing
// assumes an AXI4-Lite master on aclk and sample ports synchronous to aclk
`timescale 1ns/1ps
`include "dpm_regs.vh"

// Behaviour
// - Sleep and power-down are set by bits 3 and 4 of control register 0.
// - Sleep only turns off the output currents; the datapath keeps running.
// - Leaving sleep restores full operation with no settling delay.
// - Power-down stops all datapath logic but the register port still works.
// - Sample inputs are taken as two independent ports; the one-port setting captures nothing.
// - In two-port mode both port words are captured on each data-rate edge.
// - In two-port mode the data-rate clock can be driven out to the source.
// - The exported clock goes to the shared clock/lock pin or serial-out pin.
// - With the PLL on, the shared pin may instead show the PLL lock state.
// - With the PLL off, register 3 bit 7 picks which pin carries the clock.
// - With the PLL on, register 1 bit 0 picks lock indicator or clock.
module dpm_core #(
  parameter DW       = 14,
  parameter DIVW     = 8,
  parameter [7:0] ID = 8'h5a  // arbitrary identity value
) (
  input  wire            aclk,
  input  wire            aresetn,
  input  wire [5:0]      s_axi_awaddr,
  input  wire            s_axi_awvalid,
  output wire            s_axi_awready,
  input  wire [31:0]     s_axi_wdata,
  input  wire [3:0]      s_axi_wstrb,
  input  wire            s_axi_wvalid,
  output wire            s_axi_wready,
  output reg  [1:0]      s_axi_bresp,
  output reg             s_axi_bvalid,
  input  wire            s_axi_bready,
  input  wire [5:0]      s_axi_araddr,
  input  wire            s_axi_arvalid,
  output wire            s_axi_arready,
  output reg  [31:0]     s_axi_rdata,
  output reg  [1:0]      s_axi_rresp,
  output reg             s_axi_rvalid,
  input  wire            s_axi_rready,
  input  wire [DW-1:0]   port1_data,
  input  wire [DW-1:0]   port2_data,
  input  wire            pll_locked,
  input  wire [DIVW-1:0] rate_divisor,
  output reg  [DW-1:0]   chan_i,
  output reg  [DW-1:0]   chan_q,
  output reg             sample_valid,
  output reg             dac_current_on,
  output reg             datapath_on,
  output reg             shared_clock_or_lock_pin,
  output reg             shared_clock_or_lock_oe,
  output reg             sdo_out,
  output reg             sdo_oe,
  output wire            irq
);

  reg [7:0]  ctrl0;
  reg [7:0]  ctrl1;
  reg [7:0]  ctrl2;
  reg [7:0]  ctrl3;
  reg [7:0]  ctrl4;
  reg [3:0]  status;
  reg [3:0]  mask;
  reg        aw_held;
  reg        w_held;
  reg [5:0]  aw_addr;
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  reg        lock_q;
  reg        pd_q;
  reg [4:0]  flush_cnt;
  reg        flush_busy;
  reg [3:0]  ev;
  reg [31:0] next_rdata;
  reg        next_rerr;

  wire       sleep_on  = ctrl0[`DPM_BIT_SLEEP];
  wire       pd_on     = ctrl0[`DPM_BIT_PWRDN];
  wire       one_port  = ctrl2[`DPM_BIT_ONEPORT];
  wire       pll_on    = ctrl4[`DPM_BIT_PLL_ON];
  wire       clk_to_sdo = ctrl3[`DPM_BIT_CLK_SDO];
  wire       clk_export = ctrl3[`DPM_BIT_CLK_EN];
  wire       do_write  = aw_held && w_held && !s_axi_bvalid;
  wire [3:0] widx      = aw_addr[5:2];
  wire [3:0] ridx      = s_axi_araddr[5:2];
  wire       rd_take   = s_axi_arvalid && s_axi_arready;
  wire       tick;
  wire       phase;

  // rate divider runs unless powered down; sleep leaves it alone
  dpm_rate_div #(
    .WIDTH   (DIVW)
  ) u_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (!pd_on),
    .divisor (rate_divisor),
    .tick    (tick),
    .phase   (phase)
  );

  // address and data are latched separately, so either may come first
  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign s_axi_arready = !s_axi_rvalid;

  // byte-lane write of an 8-bit register
  function [7:0] wr8;
    input [7:0]  old;
    input [31:0] d;
    input [3:0]  s;
    begin
      wr8 = s[0] ? d[7:0] : old;
    end
  endfunction

  // write channel and control registers; no reset path tied to power state
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 6'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
      ctrl0 <= `DPM_RST_CTRL;
      ctrl1 <= `DPM_RST_CTRL;
      ctrl2 <= `DPM_RST_CTRL;
      ctrl3 <= `DPM_RST_CTRL3;
      ctrl4 <= `DPM_RST_CTRL;
      mask  <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'b00;
        // registers stay writable in every power state
        case (widx)
          `DPM_IDX_CTRL0: ctrl0 <= wr8(ctrl0, w_data, w_strb);
          `DPM_IDX_CTRL1: ctrl1 <= wr8(ctrl1, w_data, w_strb);
          `DPM_IDX_CTRL2: ctrl2 <= wr8(ctrl2, w_data, w_strb);
          `DPM_IDX_CTRL3: ctrl3 <= wr8(ctrl3, w_data, w_strb);
          `DPM_IDX_CTRL4: ctrl4 <= wr8(ctrl4, w_data, w_strb);
          `DPM_IDX_MASK:  mask  <= w_strb[0] ? w_data[3:0] : mask;
          `DPM_IDX_STATUS: s_axi_bresp <= 2'b00;
          default:        s_axi_bresp <= 2'b10;
        endcase
      end
    end
  end

  // read mux; status and sample words show live block state
  always @* begin
    next_rdata = 32'h0000_0000;
    next_rerr  = 1'b0;
    case (ridx)
      `DPM_IDX_CTRL0:  next_rdata = {24'h000000, ctrl0};
      `DPM_IDX_CTRL1:  next_rdata = {24'h000000, ctrl1};
      `DPM_IDX_CTRL2:  next_rdata = {24'h000000, ctrl2};
      `DPM_IDX_CTRL3:  next_rdata = {24'h000000, ctrl3};
      `DPM_IDX_CTRL4:  next_rdata = {24'h000000, ctrl4};
      `DPM_IDX_STATUS: next_rdata = {ID, 16'h0000, lock_q, flush_busy,
                                     2'b00, status};
      `DPM_IDX_MASK:   next_rdata = {28'h0000000, mask};
      `DPM_IDX_SAMPLE: next_rdata = {2'b00, chan_q, 2'b00, chan_i};
      default:         next_rerr  = 1'b1;
    endcase
  end

  // read channel: answer one cycle after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rerr ? 2'b10 : 2'b00;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // events: lock edges, power-down exit, filter flush complete
  always @* begin
    ev = 4'h0;
    ev[`DPM_ST_LOCK_RISE] = pll_on && pll_locked && !lock_q;
    ev[`DPM_ST_LOCK_FALL] = pll_on && !pll_locked && lock_q;
    ev[`DPM_ST_PD_EXIT]   = pd_q && !pd_on;
    ev[`DPM_ST_FLUSHED]   = flush_busy && tick && flush_cnt == 5'd1;
  end

  // sticky status; a read clears it but a same-cycle event still sets
  always @(posedge aclk) begin
    if (!aresetn) begin
      status <= 4'h0;
      lock_q <= 1'b0;
      pd_q   <= 1'b0;
    end else begin
      lock_q <= pll_locked;
      pd_q   <= pd_on;
      if (rd_take && ridx == `DPM_IDX_STATUS)
        status <= ev;
      else
        status <= status | ev;
    end
  end

  assign irq = |(status & mask);

  // count data-rate words after power-down so software sees the flush
  always @(posedge aclk) begin
    if (!aresetn) begin
      flush_cnt  <= 5'd0;
      flush_busy <= 1'b0;
    end else if (pd_on) begin
      flush_cnt  <= `DPM_FLUSH_WORDS;
      flush_busy <= 1'b1;
    end else if (flush_busy && tick) begin
      flush_cnt  <= flush_cnt - 5'd1;
      if (flush_cnt == 5'd1)
        flush_busy <= 1'b0;
    end
  end

  // capture both ports on each data-rate edge in two-port mode; frozen in power-down
  always @(posedge aclk) begin
    if (!aresetn) begin
      chan_i       <= {DW{1'b0}};
      chan_q       <= {DW{1'b0}};
      sample_valid <= 1'b0;
    end else if (pd_on) begin
      sample_valid <= 1'b0;
    end else if (tick && !one_port) begin
      chan_i       <= port1_data;
      chan_q       <= port2_data;
      sample_valid <= 1'b1;
    end else begin
      // one-port interleave lies outside this block; no samples there
      sample_valid <= 1'b0;
    end
  end

  // power controls: sleep drops only the output currents, at once
  always @(posedge aclk) begin
    if (!aresetn) begin
      dac_current_on <= 1'b0;
      datapath_on    <= 1'b0;
    end else begin
      dac_current_on <= !sleep_on && !pd_on;
      datapath_on    <= !pd_on;
    end
  end

  // pin routing for the exported clock and the lock indicator
  always @(posedge aclk) begin
    if (!aresetn) begin
      shared_clock_or_lock_pin <= 1'b0;
      shared_clock_or_lock_oe  <= 1'b0;
      sdo_out <= 1'b0;
      sdo_oe  <= 1'b0;
    end else begin
      shared_clock_or_lock_pin <= 1'b0;
      shared_clock_or_lock_oe  <= 1'b0;
      sdo_out <= 1'b0;
      sdo_oe  <= 1'b0;
      if (pll_on && !ctrl1[`DPM_BIT_LOCK_CLK]) begin
        // lock indicator replaces the clock on the selected pin
        if (clk_to_sdo) begin
          sdo_out <= pll_locked;
          sdo_oe  <= 1'b1;
        end else begin
          shared_clock_or_lock_pin <= pll_locked;
          shared_clock_or_lock_oe  <= 1'b1;
        end
      end else if (clk_export && !one_port && !pd_on) begin
        // inversion only flips the level, no other timing effect
        if (clk_to_sdo) begin
          sdo_out <= phase ^ ctrl2[`DPM_BIT_CLKINV];
          sdo_oe  <= 1'b1;
        end else begin
          shared_clock_or_lock_pin <= phase ^ ctrl2[`DPM_BIT_CLKINV];
          shared_clock_or_lock_oe  <= 1'b1;
        end
      end
    end
  end

endmodule // dpm_core

// ==== testbench/dpm_core_monitor.sv ====
// dpm_core_monitor.sv: port-level checks of the power-mode block
// assumes a bind into dpm_core; sees only the top module ports
`timescale 1ns/1ps
module dpm_core_monitor #(
  parameter DW = 14
) (
  input logic          aclk,
  input logic          aresetn,
  input logic          s_axi_awvalid,
  input logic          s_axi_awready,
  input logic          s_axi_wvalid,
  input logic          s_axi_wready,
  input logic          s_axi_bvalid,
  input logic          s_axi_bready,
  input logic          s_axi_arvalid,
  input logic          s_axi_arready,
  input logic          s_axi_rvalid,
  input logic          s_axi_rready,
  input logic          sample_valid,
  input logic          dac_current_on,
  input logic          datapath_on,
  input logic [DW-1:0] port1_data,
  input logic [DW-1:0] port2_data,
  input logic [DW-1:0] chan_i,
  input logic [DW-1:0] chan_q
);
  // one domain, so one clock and reset for all
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // both write channels handed over at one edge
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // read answer on offer, not yet taken
  sequence s_rd_wait;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  // power-down keeps the currents off and, past its first cycle, allows no capture
  chk_pd_currents: assert property (!datapath_on |-> !dac_current_on)
    else $error("currents on in power-down");
  chk_pd_capture: assert property (
    !datapath_on && !$past(datapath_on) |-> !sample_valid)
    else $error("capture in power-down");
  chk_capture_i: assert property (
    sample_valid |-> chan_i == $past(port1_data))
    else $error("port 1 word lost");
  chk_capture_q: assert property (
    sample_valid |-> chan_q == $past(port2_data))
    else $error("port 2 word lost");
  // answers come in bounded time and stand until taken
  chk_write_resp: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  chk_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  chk_r_hold: assert property (s_rd_wait |=> s_axi_rvalid)
    else $error("read answer dropped");
  chk_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule // dpm_core_monitor

bind dpm_core dpm_core_monitor #(.DW(DW)) u_mon (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .sample_valid, .dac_current_on,
  .datapath_on, .port1_data, .port2_data, .chan_i, .chan_q);

// ==== testbench/dpm_sample_src.sv ====
// dpm_sample_src.sv: model of the two-port sample source
// assumes sample_valid marks every capture edge of the block
`timescale 1ns/1ps
module dpm_sample_src #(
  parameter DW = 14
) (
  input  logic          aclk,
  input  logic          aresetn,
  input  logic          sample_valid,
  output logic [DW-1:0] port1_data,
  output logic [DW-1:0] port2_data
);
  logic [DW-1:0] word;
  // new pair only after a capture, so both words meet one edge
  always @(posedge aclk) begin
    if (!aresetn)
      word <= '0;
    else if (sample_valid)
      word <= word + DW'(8'h25);
  end
  // port 2 inverted so a lane swap cannot pass
  assign port1_data = word;
  assign port2_data = ~word;
endmodule // dpm_sample_src

// ==== testbench/dpm_core_tb.sv ====
// dpm_core_tb.sv: self-checking bench of power modes, capture, pins
// assumes dpm_regs.vh on the include path and the source model
`timescale 1ns/1ps
`include "dpm_regs.vh"
module dpm_core_tb;
  logic        aclk = 1'b0, aresetn = 1'b0, pll_locked = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic [5:0]  s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0, rval, s_axi_rdata;
  logic [7:0]  rate_divisor = 8'h03;
  logic [1:0]  resp, s_axi_bresp, s_axi_rresp;
  logic [13:0] port1_data, port2_data, chan_i, chan_q;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, sample_valid, dac_current_on, datapath_on;
  logic        shared_clock_or_lock_pin, shared_clock_or_lock_oe;
  logic        sdo_out, sdo_oe, irq;
  int          errors = 0, n_compared = 0, cyc = 0;

  dpm_core DUT (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .port1_data, .port2_data, .pll_locked,
    .rate_divisor, .chan_i, .chan_q, .sample_valid, .dac_current_on,
    .datapath_on, .shared_clock_or_lock_pin, .shared_clock_or_lock_oe,
    .sdo_out, .sdo_oe, .irq);
  dpm_sample_src SRC (
    .aclk, .aresetn, .sample_valid, .port1_data, .port2_data);

  // 100 MHz
  always #5 aclk = ~aclk;

  task automatic summarize;
    if (errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // compare; an unknown never passes
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // write one control byte; each channel let go once taken
  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
  endtask
  task automatic rd(input logic [3:0] idx);
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    rval = s_axi_rdata;
    resp = s_axi_rresp;
  endtask
  // cycles to the next capture; 40 means none came
  task automatic next_cap(output int n);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (sample_valid !== 1'b1 && n < 40);
  endtask

  task automatic t_regs;
    rd(`DPM_IDX_CTRL3);
    ck(rval, 32'h01);
    wr(`DPM_IDX_SAMPLE, 8'h00);
    ck(resp, 2'b10);
    rd(4'h9);
    ck(resp, 2'b10);
  endtask
  // first gap may be partial, so it is skipped
  task automatic t_capture;
    int n;
    next_cap(n);
    repeat (3) begin
      next_cap(n);
      ck(n, rate_divisor + 1);
      ck(chan_i, port1_data);
      ck(chan_q, port2_data);
    end
    wr(`DPM_IDX_CTRL2, 8'h40);
    next_cap(n);
    ck(n, 40);
    wr(`DPM_IDX_CTRL2, 8'h00);
  endtask
  task automatic t_sleep;
    int n;
    wr(`DPM_IDX_CTRL0, 8'h08);
    next_cap(n);
    ck(n < 40, 1);
    ck(dac_current_on, 0);
    ck(datapath_on, 1);
    wr(`DPM_IDX_CTRL0, 8'h00);
    @(posedge aclk);
    ck(dac_current_on, 1);
  endtask
  // power-down, then exit events raised, masked, read away
  task automatic t_pd;
    int n;
    wr(`DPM_IDX_CTRL3, 8'h81);
    wr(`DPM_IDX_MASK, 8'h00);
    wr(`DPM_IDX_CTRL0, 8'h10);
    next_cap(n);
    ck(n, 40);
    ck(datapath_on, 0);
    ck(dac_current_on, 0);
    rd(`DPM_IDX_CTRL3);
    ck(rval, 32'h81);
    wr(`DPM_IDX_CTRL0, 8'h00);
    repeat (`DPM_FLUSH_WORDS * (rate_divisor + 1) + 8) @(posedge aclk);
    ck(irq, 0);
    wr(`DPM_IDX_MASK, 8'h0c);
    @(posedge aclk);
    ck(irq, 1);
    rd(`DPM_IDX_STATUS);
    ck(rval[7:0], 8'h0c);
    @(posedge aclk);
    ck(irq, 0);
  endtask
  // ctrl4, ctrl1, ctrl3, then {clock, shared oe, sdo oe}
  task automatic t_pins;
    logic [31:0] cfg [6] = '{32'h00000106, 32'h00008105, 32'h80008101,
                             32'h80000102, 32'h80010106, 32'h00000000};
    logic p, q;
    int n;
    pll_locked <= 1'b1;
    foreach (cfg[i]) begin
      wr(`DPM_IDX_CTRL4, cfg[i][31:24]);
      wr(`DPM_IDX_CTRL1, cfg[i][23:16]);
      wr(`DPM_IDX_CTRL3, cfg[i][15:8]);
      n = 0;
      repeat (8) begin
        @(posedge aclk);
        p = cfg[i][0] ? sdo_out : shared_clock_or_lock_pin;
        if (p !== q) n++;
        q = p;
      end
      ck(shared_clock_or_lock_oe, cfg[i][1]);
      ck(sdo_oe, cfg[i][0]);
      if (cfg[i][2]) ck(n > 2, 1);
      else if (cfg[i][1:0] != 2'b00) ck(p, 1);
    end
  endtask
  // lock edges reach the sticky status only with the PLL on
  task automatic t_lock;
    wr(`DPM_IDX_CTRL4, 8'h80);
    rd(`DPM_IDX_STATUS);
    ck(rval[7:0], 8'h80);
    pll_locked <= 1'b0;
    repeat (2) @(posedge aclk);
    rd(`DPM_IDX_STATUS);
    ck(rval[7:0], 8'h02);
    pll_locked <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(`DPM_IDX_STATUS);
    ck(rval[7:0], 8'h81);
    wr(`DPM_IDX_CTRL4, 8'h00);
  endtask

  // four-cycle reset, then the scenarios
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_capture;
    t_sleep;
    t_pd;
    t_pins;
    t_lock;
    summarize;
  end
  // hang guard, well above the run's few hundred cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      summarize;
    end
  end
endmodule // dpm_core_tb
